// ### hdl/fts_pkg.sv
// Purpose: constants, types and register map of the framed test signal generator
// Assumes: one 250 MHz clock, line bit rate set by a divider register
`default_nettype none
package fts_pkg;
  // framing modes
  typedef enum logic [2:0] {FTS_MODE_FULL, FTS_MODE_INPUT, FTS_MODE_SF, FTS_MODE_ESF,
                            FTS_MODE_E1CCS, FTS_MODE_E1CAS} fts_mode_type;
  typedef enum logic [1:0] {FTS_SIG_TWO, FTS_SIG_FOUR, FTS_SIG_SIXTEEN} fts_sig_type;
  // register indices and byte offsets
  localparam int unsigned FTS_NREG = 10;
  localparam int unsigned FTS_IDX_CTRL = 0;
  localparam int unsigned FTS_IDX_DIV = 1;
  localparam int unsigned FTS_IDX_FRAMING = 2;
  localparam int unsigned FTS_IDX_DLCAS = 3;
  localparam int unsigned FTS_IDX_FSFAS = 4;
  localparam int unsigned FTS_IDX_SIGA = 5;
  localparam int unsigned FTS_IDX_STATUS = 9;
  localparam logic [7:0] FTS_OFF_STATUS = 8'h24;
  // field positions
  localparam int unsigned FTS_CTRL_EN = 0;
  localparam int unsigned FTS_CTRL_MODE_LSB = 1;
  localparam int unsigned FTS_CTRL_TRANS = 4;
  localparam int unsigned FTS_CTRL_SIG_LSB = 5;
  localparam int unsigned FTS_SF_F_LSB = 0;
  localparam int unsigned FTS_SF_S_LSB = 6;
  localparam int unsigned FTS_ESF_F_LSB = 12;
  localparam int unsigned FTS_ESF_C_LSB = 18;
  localparam int unsigned FTS_E1_RA = 24;
  localparam int unsigned FTS_E1_SPARE_LSB = 25;
  localparam int unsigned FTS_DL_LSB = 0;
  localparam int unsigned FTS_CAS_LSB = 12;
  localparam int unsigned FTS_FAS_LSB = 0;
  localparam int unsigned FTS_CJ_LSB = 12;
  // writable bits per register, reserved bits read zero
  localparam logic [FTS_NREG-1:0][31:0] FTS_REG_MASK = {32'h0000_0000, {4{32'h00ff_ffff}},
    32'h00ff_ffff, 32'h000f_ffff, 32'h3fff_ffff, 32'h0000_ffff, 32'h0000_007f};
  // frame geometry
  localparam int unsigned FTS_FS_SETS = 4;
  localparam int unsigned FTS_FS_SET_BITS = 212;
  localparam int unsigned FTS_FS_FAS_BITS = 12;
  localparam int unsigned FTS_FS_CJ_BITS = 4;
  localparam logic [9:0] FTS_FS_FRAME_BITS = 10'(FTS_FS_SETS * FTS_FS_SET_BITS);
  localparam logic [9:0] FTS_SF_FRAME_BITS = 10'h0c1;
  localparam logic [4:0] FTS_SF_FRAMES = 5'h0c;
  localparam logic [4:0] FTS_ESF_FRAMES = 5'h18;
  localparam logic [9:0] FTS_E1_FRAME_BITS = 10'h100;
  localparam logic [4:0] FTS_E1_FRAMES = 5'h02;
  localparam logic [9:0] FTS_E1_SLOT_BITS = 10'h008;
  localparam logic [9:0] FTS_E1_SLOT16 = 10'h080;
  localparam logic [7:0] FTS_E1_FAS = 8'h9b;
  localparam logic [4:0] FTS_FRM_06 = 5'h05;
  localparam logic [4:0] FTS_FRM_12 = 5'h0b;
  localparam logic [4:0] FTS_FRM_18 = 5'h11;
  localparam logic [4:0] FTS_FRM_24 = 5'h17;
  // test sequence generator seed and bus response codes
  localparam logic [14:0] FTS_PRBS_SEED = 15'h7fff;
  localparam logic [1:0] FTS_RESP_OKAY = 2'h0;
  localparam logic [1:0] FTS_RESP_SLVERR = 2'h2;
  // carriers
  typedef logic [FTS_NREG-1:0][31:0] fts_regs_type;
  typedef struct packed {logic pay; logic val;} fts_cls_type;
  typedef struct packed {logic data; logic strobe; logic overhead; logic frame_start;} fts_line_type;
  typedef struct packed {
    fts_regs_type regs;
    logic aw_full; logic [7:0] aw_addr; logic w_full; logic [31:0] w_data; logic [3:0] w_strb;
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    logic [15:0] div_cnt; logic [9:0] pos; logic [4:0] frm; logic [14:0] prbs;
    fts_line_type line;
  } fts_state_type;
endpackage
`default_nettype wire

// ### hdl/fts_top.sv
// Purpose: framed test signal generator, bit serial, with an AXI4-Lite register slave
// Assumes: line bit strobe from a programmable divider of the 250 MHz clock
// Notes: one state struct, one always_comb builds the next copy, one always_ff stores it
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module fts_top (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // axi4-lite write channels
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output var logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output var logic S_AXI_WREADY_O,
  output var logic [1:0] S_AXI_BRESP_O,
  output var logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read channels
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output var logic S_AXI_ARREADY_O,
  output var logic [31:0] S_AXI_RDATA_O,
  output var logic [1:0] S_AXI_RRESP_O,
  output var logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // serial line toward the equipment under test
  output var fts_pkg::fts_line_type LINE_O
);

  fts_pkg::fts_state_type st_q;
  fts_pkg::fts_state_type st_d;
  fts_pkg::fts_mode_type cur_mode;
  fts_pkg::fts_cls_type cur_cls;
  logic bit_en;
  logic [4:0] wdec;
  logic [4:0] rdec;
  logic [9:0] frame_bits;
  logic [4:0] frame_count;

  ////////////////////////////////////////////////////////////////////////////
  // address decode: {hit, index}; unaligned or past the map is a miss
  function automatic logic [4:0] fts_decode(input logic [7:0] a);
    if (a[1:0] != 2'h0) begin
      fts_decode = 5'h00;
    end else if (a > fts_pkg::FTS_OFF_STATUS) begin
      fts_decode = 5'h00;
    end else begin
      fts_decode = {1'b1, a[5:2]};
    end
  endfunction

  // bits per frame for each mode
  function automatic logic [9:0] fts_frame_len(input fts_pkg::fts_mode_type m);
    case (m)
      fts_pkg::FTS_MODE_SF, fts_pkg::FTS_MODE_ESF: fts_frame_len = fts_pkg::FTS_SF_FRAME_BITS;
      fts_pkg::FTS_MODE_E1CCS, fts_pkg::FTS_MODE_E1CAS: fts_frame_len = fts_pkg::FTS_E1_FRAME_BITS;
      default: fts_frame_len = fts_pkg::FTS_FS_FRAME_BITS;
    endcase
  endfunction

  // frames per multiframe for each mode
  function automatic logic [4:0] fts_frame_cnt(input fts_pkg::fts_mode_type m);
    case (m)
      fts_pkg::FTS_MODE_SF: fts_frame_cnt = fts_pkg::FTS_SF_FRAMES;
      fts_pkg::FTS_MODE_ESF: fts_frame_cnt = fts_pkg::FTS_ESF_FRAMES;
      fts_pkg::FTS_MODE_E1CCS, fts_pkg::FTS_MODE_E1CAS: fts_frame_cnt = fts_pkg::FTS_E1_FRAMES;
      default: fts_frame_cnt = 5'h01;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // classify one bit position: payload, or overhead with its value
  function automatic fts_pkg::fts_cls_type fts_classify(input fts_pkg::fts_mode_type m,
      input logic [9:0] pos, input logic [4:0] frm, input fts_pkg::fts_regs_type r);
    logic [31:0] ctl;
    logic [31:0] frw;
    logic tr;
    fts_pkg::fts_sig_type st;
    logic [4:0] ch;
    int unsigned sel;
    logic [7:0] ts0;
    fts_pkg::fts_cls_type c;
    ctl = r[fts_pkg::FTS_IDX_CTRL];
    frw = r[fts_pkg::FTS_IDX_FRAMING];
    tr = ctl[fts_pkg::FTS_CTRL_TRANS];
    st = fts_pkg::fts_sig_type'(ctl[fts_pkg::FTS_CTRL_SIG_LSB +: 2]);
    ch = pos[7:3] - 5'h01;
    sel = 0;
    ts0 = {2'h3, frw[fts_pkg::FTS_E1_RA], frw[fts_pkg::FTS_E1_SPARE_LSB +: 5]};
    c.pay = 1'b1;
    c.val = 1'b0;
    case (m)
      fts_pkg::FTS_MODE_FULL: begin
        // set one opens with the alignment word plus alarm bits
        if (pos < 10'(fts_pkg::FTS_FS_FAS_BITS)) begin
          c.pay = 1'b0;
          c.val = r[fts_pkg::FTS_IDX_FSFAS][fts_pkg::FTS_FAS_LSB + 32'(pos)];
        end
        // sets two to four open with justification control bits
        for (int s = 1; s < fts_pkg::FTS_FS_SETS; s++) begin
          if (32'(pos) >= s * fts_pkg::FTS_FS_SET_BITS &&
              32'(pos) < s * fts_pkg::FTS_FS_SET_BITS + fts_pkg::FTS_FS_CJ_BITS) begin
            c.pay = 1'b0;
            c.val = r[fts_pkg::FTS_IDX_FSFAS][fts_pkg::FTS_CJ_LSB + (s - 1) * fts_pkg::FTS_FS_CJ_BITS
                    + 32'(pos) - s * fts_pkg::FTS_FS_SET_BITS];
          end
        end
      end
      fts_pkg::FTS_MODE_INPUT: begin
        // alignment word only, no justification info at all
        if (pos < 10'(fts_pkg::FTS_FS_FAS_BITS)) begin
          c.pay = 1'b0;
          c.val = r[fts_pkg::FTS_IDX_FSFAS][fts_pkg::FTS_FAS_LSB + 32'(pos)];
        end
      end
      fts_pkg::FTS_MODE_SF: begin
        if (pos == 10'h000) begin
          // even frames take F bits, odd frames S bits
          c.pay = 1'b0;
          c.val = frm[0] ? frw[fts_pkg::FTS_SF_S_LSB + 32'(frm[4:1])]
                         : frw[fts_pkg::FTS_SF_F_LSB + 32'(frm[4:1])];
        end else if ((frm == fts_pkg::FTS_FRM_06 || frm == fts_pkg::FTS_FRM_12) && !tr &&
                     pos[2:0] == 3'h0) begin
          c.pay = 1'b0;
          if (frm == fts_pkg::FTS_FRM_12 && st != fts_pkg::FTS_SIG_TWO) begin
            sel = 1;
          end
          c.val = r[fts_pkg::FTS_IDX_SIGA + sel][ch];
        end
      end
      fts_pkg::FTS_MODE_ESF: begin
        if (pos == 10'h000) begin
          c.pay = 1'b0;
          case (frm[1:0])
            2'h1: c.val = frw[fts_pkg::FTS_ESF_C_LSB + 32'(frm[4:2])];
            2'h3: c.val = frw[fts_pkg::FTS_ESF_F_LSB + 32'(frm[4:2])];
            default: c.val = r[fts_pkg::FTS_IDX_DLCAS][fts_pkg::FTS_DL_LSB + 32'(frm[4:1])];
          endcase
        end else if ((frm == fts_pkg::FTS_FRM_06 || frm == fts_pkg::FTS_FRM_12 || frm == fts_pkg::FTS_FRM_18 ||
                      frm == fts_pkg::FTS_FRM_24) && !tr && pos[2:0] == 3'h0) begin
          c.pay = 1'b0;
          // signalling letter chosen by the configured state count
          if (frm == fts_pkg::FTS_FRM_12) begin
            sel = (st == fts_pkg::FTS_SIG_TWO) ? 0 : 1;
          end else if (frm == fts_pkg::FTS_FRM_18) begin
            sel = (st == fts_pkg::FTS_SIG_SIXTEEN) ? 2 : 0;
          end else if (frm == fts_pkg::FTS_FRM_24) begin
            sel = (st == fts_pkg::FTS_SIG_TWO) ? 0 : ((st == fts_pkg::FTS_SIG_FOUR) ? 1 : 3);
          end
          c.val = r[fts_pkg::FTS_IDX_SIGA + sel][ch];
        end
      end
      fts_pkg::FTS_MODE_E1CCS, fts_pkg::FTS_MODE_E1CAS: begin
        // slot zero alternates, sent most significant bit first
        if (pos < fts_pkg::FTS_E1_SLOT_BITS) begin
          c.pay = 1'b0;
          c.val = frm[0] ? ts0[3'h7 - pos[2:0]] : fts_pkg::FTS_E1_FAS[3'h7 - pos[2:0]];
        end else if (m == fts_pkg::FTS_MODE_E1CAS && pos >= fts_pkg::FTS_E1_SLOT16 &&
                     pos < fts_pkg::FTS_E1_SLOT16 + fts_pkg::FTS_E1_SLOT_BITS) begin
          c.pay = 1'b0;
          c.val = r[fts_pkg::FTS_IDX_DLCAS][fts_pkg::FTS_CAS_LSB + 32'(3'h7 - pos[2:0])];
        end
      end
      default: begin
        c.pay = 1'b1;
      end
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // current position decode, shared by next-state logic and checks
  assign cur_mode = fts_pkg::fts_mode_type'(st_q.regs[fts_pkg::FTS_IDX_CTRL][fts_pkg::FTS_CTRL_MODE_LSB +: 3]);
  assign bit_en = st_q.regs[fts_pkg::FTS_IDX_CTRL][fts_pkg::FTS_CTRL_EN] && st_q.div_cnt == 16'h0000;
  assign cur_cls = fts_classify(cur_mode, st_q.pos, st_q.frm, st_q.regs);
  assign frame_bits = fts_frame_len(cur_mode);
  assign frame_count = fts_frame_cnt(cur_mode);

  // next state: bus slave and framer
  always_comb begin
    st_d = st_q;
    // write address and data may arrive in either order
    if (S_AXI_AWVALID_I && st_q.awready) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && st_q.wready) begin
      st_d.w_full = 1'b1;
      st_d.w_data = S_AXI_WDATA_I;
      st_d.w_strb = S_AXI_WSTRB_I;
    end
    if (st_q.bvalid && S_AXI_BREADY_I) begin
      st_d.bvalid = 1'b0;
    end
    wdec = fts_decode(st_d.aw_addr);
    if (st_d.aw_full && st_d.w_full && !st_d.bvalid) begin
      // status is read only; writes to it answer with an error
      if (wdec[4] && 32'(wdec[3:0]) != fts_pkg::FTS_IDX_STATUS) begin
        for (int b = 0; b < 4; b++) begin
          if (st_d.w_strb[b]) begin
            st_d.regs[wdec[3:0]][8*b +: 8] = st_d.w_data[8*b +: 8];
          end
        end
        st_d.regs[wdec[3:0]] = st_d.regs[wdec[3:0]] & fts_pkg::FTS_REG_MASK[wdec[3:0]];
        st_d.bresp = fts_pkg::FTS_RESP_OKAY;
      end else begin
        st_d.bresp = fts_pkg::FTS_RESP_SLVERR;
      end
      st_d.bvalid = 1'b1;
      st_d.aw_full = 1'b0;
      st_d.w_full = 1'b0;
    end
    st_d.awready = !st_d.aw_full && !st_d.bvalid;
    st_d.wready = !st_d.w_full && !st_d.bvalid;
    // read: one outstanding, answered the cycle after the address
    if (st_q.rvalid && S_AXI_RREADY_I) begin
      st_d.rvalid = 1'b0;
    end
    rdec = fts_decode(S_AXI_ARADDR_I);
    if (S_AXI_ARVALID_I && st_q.arready) begin
      st_d.rvalid = 1'b1;
      if (!rdec[4]) begin
        st_d.rdata = 32'h0000_0000;
        st_d.rresp = fts_pkg::FTS_RESP_SLVERR;
      end else if (32'(rdec[3:0]) == fts_pkg::FTS_IDX_STATUS) begin
        st_d.rdata = {17'h00000, st_q.frm, st_q.pos};
        st_d.rresp = fts_pkg::FTS_RESP_OKAY;
      end else begin
        st_d.rdata = st_q.regs[rdec[3:0]];
        st_d.rresp = fts_pkg::FTS_RESP_OKAY;
      end
    end
    st_d.arready = !st_d.rvalid;
    // framer: one line bit per divider wrap
    st_d.line.strobe = 1'b0;
    st_d.line.frame_start = 1'b0;
    if (!st_q.regs[fts_pkg::FTS_IDX_CTRL][fts_pkg::FTS_CTRL_EN]) begin
      // disabling restarts the frame; the sequence holds its place and carries on from there
      st_d.pos = 10'h000;
      st_d.frm = 5'h00;
      st_d.div_cnt = 16'h0000;
    end else if (!bit_en) begin
      st_d.div_cnt = st_q.div_cnt - 16'h0001;
    end else begin
      st_d.div_cnt = st_q.regs[fts_pkg::FTS_IDX_DIV][15:0];
      st_d.line.strobe = 1'b1;
      st_d.line.overhead = !cur_cls.pay;
      st_d.line.frame_start = st_q.pos == 10'h000 && st_q.frm == 5'h00;
      // payload bits run straight on, slot after slot
      st_d.line.data = cur_cls.pay ? st_q.prbs[14] : cur_cls.val;
      // the generator steps only on payload bits; one sequence feeds every set
      if (cur_cls.pay) begin
        st_d.prbs = {st_q.prbs[13:0], st_q.prbs[14] ^ st_q.prbs[13]};
      end
      // >= guards a mode change that leaves pos past the new frame end
      if (st_q.pos >= frame_bits - 10'h001) begin
        st_d.pos = 10'h000;
        st_d.frm = (st_q.frm >= frame_count - 5'h01) ? 5'h00 : st_q.frm + 5'h01;
      end else begin
        st_d.pos = st_q.pos + 10'h001;
      end
    end
    // synchronous reset; seed must never be all zero
    if (SYS_RST_I) begin
      st_d = '0;
      st_d.prbs = fts_pkg::FTS_PRBS_SEED;
    end
  end

  // state register
  always_ff @(posedge CLOCK_I) begin
    st_q <= st_d;
  end

  // outputs straight from the state flops
  assign S_AXI_AWREADY_O = st_q.awready;
  assign S_AXI_WREADY_O = st_q.wready;
  assign S_AXI_BVALID_O = st_q.bvalid;
  assign S_AXI_BRESP_O = st_q.bresp;
  assign S_AXI_ARREADY_O = st_q.arready;
  assign S_AXI_RVALID_O = st_q.rvalid;
  assign S_AXI_RDATA_O = st_q.rdata;
  assign S_AXI_RRESP_O = st_q.rresp;
  assign LINE_O = st_q.line;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the framer
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_SF_LEN: assert property (cur_mode == fts_pkg::FTS_MODE_SF && st_q.pos < fts_pkg::FTS_SF_FRAME_BITS
    |-> ##1 (st_q.frm < fts_pkg::FTS_SF_FRAMES)) else $error("superframe index out of range");
  AST_ESF_LEN: assert property (cur_mode == fts_pkg::FTS_MODE_ESF && st_q.pos < fts_pkg::FTS_SF_FRAME_BITS
    |-> ##1 (st_q.frm < fts_pkg::FTS_ESF_FRAMES)) else $error("extended index out of range");
  AST_PRBS_HOLD: assert property (bit_en && !cur_cls.pay |=> st_q.prbs == $past(st_q.prbs))
    else $error("sequence moved on an overhead bit");
  AST_PRBS_OUT: assert property (bit_en && cur_cls.pay
    |=> LINE_O.strobe && !LINE_O.overhead && LINE_O.data == $past(st_q.prbs[14]) && st_q.prbs != $past(st_q.prbs))
    else $error("payload bit not from the sequence");

  AST_SF_FBIT: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_SF && st_q.pos == 10'h000
    && !st_q.frm[0]
    |=> LINE_O.overhead && LINE_O.data == $past(st_q.regs[fts_pkg::FTS_IDX_FRAMING][st_q.frm[4:1]]))
    else $error("superframe F bit wrong");
  AST_SF_SIG: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_SF && st_q.frm == fts_pkg::FTS_FRM_06
    && st_q.pos == 10'h008 && !st_q.regs[fts_pkg::FTS_IDX_CTRL][fts_pkg::FTS_CTRL_TRANS]
    |=> LINE_O.overhead && LINE_O.data == $past(st_q.regs[fts_pkg::FTS_IDX_SIGA][0]))
    else $error("channel one signalling bit wrong");
  AST_SF_TRANS: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_SF && st_q.frm == fts_pkg::FTS_FRM_06
    && st_q.pos == 10'h008 && st_q.regs[fts_pkg::FTS_IDX_CTRL][fts_pkg::FTS_CTRL_TRANS] |=> !LINE_O.overhead)
    else $error("transparent slot not payload");

  AST_E1_CCS16: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_E1CCS
    && st_q.pos == fts_pkg::FTS_E1_SLOT16
    |=> !LINE_O.overhead) else $error("slot sixteen not payload");
  AST_E1_CAS16: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_E1CAS && st_q.pos == fts_pkg::FTS_E1_SLOT16
    |=> LINE_O.overhead && LINE_O.data == $past(st_q.regs[fts_pkg::FTS_IDX_DLCAS][fts_pkg::FTS_CAS_LSB + 7]))
    else $error("slot sixteen signalling wrong");

  AST_FULL_CJ: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_FULL
    && st_q.pos == 10'(fts_pkg::FTS_FS_SET_BITS)
    |=> LINE_O.overhead && LINE_O.data == $past(st_q.regs[fts_pkg::FTS_IDX_FSFAS][fts_pkg::FTS_CJ_LSB]))
    else $error("justification bit missing");
  AST_INPUT_NOCJ: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_INPUT
    && st_q.pos == 10'(fts_pkg::FTS_FS_SET_BITS) |=> !LINE_O.overhead) else $error("input mode sent overhead");

  // bus answers stand until the master takes them; a drop would hang it
  AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped");

  AST_R_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O))
    else $error("read response dropped");

  // read data follows the address by exactly one cycle
  AST_R_LAT: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O)
    else $error("read answer late");

  // multiframe wrap points: the last bit leads back to bit zero, frame zero
  AST_SF_WRAP: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_SF
    && st_q.pos == fts_pkg::FTS_SF_FRAME_BITS - 10'h001 && st_q.frm == fts_pkg::FTS_SF_FRAMES - 5'h01
    |=> st_q.pos == 10'h000 && st_q.frm == 5'h00)
    else $error("superframe did not wrap");

  AST_ESF_WRAP: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_ESF
    && st_q.pos == fts_pkg::FTS_SF_FRAME_BITS - 10'h001 && st_q.frm == fts_pkg::FTS_ESF_FRAMES - 5'h01
    |=> st_q.pos == 10'h000 && st_q.frm == 5'h00)
    else $error("extended superframe did not wrap");

  // overhead values on the less travelled positions
  AST_ESF_CBIT: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_ESF
    && st_q.pos == 10'h000 && st_q.frm[1:0] == 2'h1
    |=> LINE_O.overhead && LINE_O.data == $past(st_q.regs[fts_pkg::FTS_IDX_FRAMING][fts_pkg::FTS_ESF_C_LSB
      + 32'(st_q.frm[4:2])]))
    else $error("extended check bit wrong");

  AST_ESF_SIG18: assert property (bit_en && cur_mode == fts_pkg::FTS_MODE_ESF && st_q.frm == fts_pkg::FTS_FRM_18
    && st_q.pos == 10'h008 && !st_q.regs[fts_pkg::FTS_IDX_CTRL][fts_pkg::FTS_CTRL_TRANS]
    && st_q.regs[fts_pkg::FTS_IDX_CTRL][fts_pkg::FTS_CTRL_SIG_LSB +: 2] == 2'h2
    |=> LINE_O.overhead && LINE_O.data == $past(st_q.regs[fts_pkg::FTS_IDX_SIGA + 2][0]))
    else $error("frame eighteen signalling wrong");

  AST_E1_FAS: assert property (bit_en && (cur_mode == fts_pkg::FTS_MODE_E1CCS || cur_mode == fts_pkg::FTS_MODE_E1CAS)
    && st_q.pos == 10'h000 && !st_q.frm[0]
    |=> LINE_O.overhead && LINE_O.data == fts_pkg::FTS_E1_FAS[7])
    else $error("slot zero alignment bit wrong");

endmodule // fts_top
`default_nettype wire

// ### dv/fts_eut_model.sv
// Purpose: far-end capture of the serial test line
// Assumes: one line bit per strobe pulse
// Notes: logs bit, overhead flag, frame start and strobe spacing
`timescale 1ns/1ns
`default_nettype none
module fts_eut_model (
  // clock
  input wire logic clk_i,
  // line from the generator
  input wire fts_pkg::fts_line_type line_i
);
  typedef struct packed {logic [7:0] gap; logic fs; logic ovh; logic dat;} fts_cap_type;
  fts_cap_type cap_q[$];
  logic [7:0] gap_q = 8'h00;
  // latch each bit on its strobe; gap lets the bench check the bit rate
  always @(posedge clk_i) begin
    gap_q <= (line_i.strobe === 1'b1) ? 8'h01 : gap_q + 8'h01;
    if (line_i.strobe === 1'b1) begin
      cap_q.push_back({gap_q, line_i.frame_start, line_i.overhead, line_i.data});
    end
  end
endmodule // fts_eut_model
`default_nettype wire

// ### dv/tb_framed_test_signal_gen.sv
// Purpose: self-checking bench for the framed test signal generator
// Assumes: AXI4-Lite master tasks, far-end capture model on the line
// Notes: payload checked against a local copy of the 15-stage sequence
`timescale 1ns/1ns
`default_nettype none
module tb_framed_test_signal_gen;
  logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  fts_pkg::fts_line_type line;
  int errors = 0, num_checks = 0;
  logic [31:0] rv [0:9];
  logic [14:0] seq_q = fts_pkg::FTS_PRBS_SEED;
  logic [31:0] ctl [0:8] = '{32'h01, 32'h03, 32'h25, 32'h15, 32'h07, 32'h27, 32'h47, 32'h09, 32'h0b};
  int nbs [0:8] = '{848, 1696, 2316, 2316, 4632, 4632, 4632, 512, 512};
  fts_top dut (.CLOCK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .LINE_O(line));
  fts_eut_model eut (.clk_i(clk), .line_i(line));
  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; a hang costs one mismatch
  initial forever #2 clk = ~clk;
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    stop_test();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // bus master: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_done, w_done;
    @(posedge clk);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awready === 1'b1 && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // expected overhead at frame f, bit p: {is_overhead, value}; 0 means payload
  function automatic logic [1:0] exp_ovh(input logic [31:0] c, input int f, input int p);
    int m, s, g;
    m = int'(c[3:1]);
    s = int'(c[6:5]);
    g = (f == 11) ? (s == 0 ? 5 : 6) : (f == 17) ? (s == 2 ? 7 : 5) : (f == 23) ? (s == 0 ? 5 : s == 1 ? 6 : 8) : 5;
    if (m < 2 && p < 12) return {1'b1, rv[4][p]};
    if (m == 0 && p % 212 < 4) return {1'b1, rv[4][8 + p / 212 * 4 + p % 212]};
    if (m == 2 && p == 0) return {1'b1, rv[2][f % 2 * 6 + f / 2]};
    if (m == 3 && p == 0) return {1'b1, (f % 2 == 0) ? rv[3][f / 2] : rv[2][(f % 4 == 1 ? 18 : 12) + f / 4]};
    if (m == 2 && (f == 5 || f == 11) && p % 8 == 0 && !c[4]) return {1'b1, rv[(f == 11 && s != 0) ? 6 : 5][p / 8 - 1]};
    if (m == 3 && f % 6 == 5 && p % 8 == 0 && !c[4]) return {1'b1, rv[g][p / 8 - 1]};
    if (m > 3 && p < 8)
      return {1'b1, (f == 0) ? fts_pkg::FTS_E1_FAS[7 - p] : (p < 2) ? 1'b1 : rv[2][p == 2 ? 24 : 32 - p]};
    if (m == 5 && p >= 128 && p < 136) return {1'b1, rv[3][147 - p]};
    return 2'b00;
  endfunction
  // one enabled burst, then every captured bit compared in frame order
  task automatic run(input logic [31:0] c, input int nb);
    logic [1:0] e;
    int f, p, k, fb, nf;
    fb = c[3:1] < 2 ? 848 : c[3:1] < 4 ? 193 : 256;
    nf = c[3:1] < 2 ? 1 : c[3:1] == 2 ? 12 : c[3:1] == 3 ? 24 : 2;
    wr(8'h00, c, r);
    for (k = 0; k < 20000 && eut.cap_q.size() < nb; k++) @(posedge clk);
    wr(8'h00, 32'h0, r);
    repeat (8) @(posedge clk);
    chk(eut.cap_q.size() >= nb, 1);
    f = 0;
    p = 0;
    for (int i = 0; i < eut.cap_q.size(); i++) begin
      e = exp_ovh(c, f, p);
      chk({eut.cap_q[i].fs, eut.cap_q[i].ovh}, {p == 0 && f == 0, e[1]});
      chk(eut.cap_q[i].dat, e[1] ? e[0] : seq_q[14]);
      if (i > 0) chk(eut.cap_q[i].gap, rv[1] + 1);
      if (!e[1]) seq_q = {seq_q[13:0], seq_q[14] ^ seq_q[13]};
      p++;
      if (p == fb) begin
        p = 0;
        f = (f + 1) % nf;
      end
    end
    eut.cap_q.delete();
    $display("test done ctrl=%h bits=%0d", c, nb);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset, register map, refused accesses, then every framing mode
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(8'(i * 4), d, r);
      chk(d, 0);
      chk(r, fts_pkg::FTS_RESP_OKAY);
    end
    for (int i = 1; i < 9; i++) begin
      rv[i] = (i == 1) ? 32'h1 : 32'h9e37_79b9 ^ (32'h1234_5678 << i);
      wr(8'(i * 4), rv[i], r);
      chk(r, fts_pkg::FTS_RESP_OKAY);
      rv[i] = rv[i] & fts_pkg::FTS_REG_MASK[i];
      rd(8'(i * 4), d, r);
      chk(d, rv[i]);
    end
    wr(fts_pkg::FTS_OFF_STATUS, 32'hffff_ffff, r);
    chk(r, fts_pkg::FTS_RESP_SLVERR);
    wr(8'h02, 32'h1, r);
    chk(r, fts_pkg::FTS_RESP_SLVERR);
    rd(8'h28, d, r);
    chk({d, r}, {32'h0, fts_pkg::FTS_RESP_SLVERR});
    $display("test done registers");
    for (int t = 0; t < 9; t++) run(ctl[t], nbs[t]);
    stop_test();
  end
endmodule // tb_framed_test_signal_gen
`default_nettype wire
